// *** src/rcc_pkg.sv ***
package rcc_pkg;

  // ==========================================================
  // Reset domains, one index per synchronised reset output
  localparam int RCC_NUM_DOM = 6;
  localparam int RCC_DOM_AON = 0;
  localparam int RCC_DOM_TIMER = 1;
  localparam int RCC_DOM_SYS = 2;
  localparam int RCC_DOM_APP = 3;
  localparam int RCC_DOM_NET = 4;
  localparam int RCC_DOM_PER = 5;

  // ==========================================================
  // Clock outputs, one index per divided and gated tick
  localparam int RCC_NUM_CLK = 6;
  localparam int RCC_CLK_PER = 0;
  localparam int RCC_CLK_NET = 1;
  localparam int RCC_CLK_APP = 2;
  localparam int RCC_CLK_HSP = 3;
  localparam int RCC_CLK_SDM = 4;
  localparam int RCC_CLK_TOUCH = 5;

  // ==========================================================
  // Pin synchroniser lanes and their reset levels
  localparam int RCC_NUM_PIN = 3;
  localparam int RCC_PIN_CHIP_EN = 0;
  localparam int RCC_PIN_BOD = 1;
  localparam int RCC_PIN_DBG = 2;
  localparam logic [2:0] RCC_PIN_RST = 3'h1;

  // ==========================================================
  // Timing and widths
  localparam int RCC_HOLD_CYCLES = 16;
  localparam int RCC_DIV_WIDTH = 8;

  // ==========================================================
  // Reset stretch sequencer
  typedef enum logic [1:0] {
    RCC_SEQ_IDLE = 2'b01,
    RCC_SEQ_HOLD = 2'b10
  } rcc_seq_type;

endpackage : rcc_pkg

// *** src/rcc_clk_div.sv ***
`timescale 1ns/10ps
module rcc_clk_div import rcc_pkg::*; #(
  parameter int WIDTH = RCC_DIV_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic src_tick,
  input wire logic gate_en,
  input wire logic [WIDTH-1:0] ratio,
  output logic tick_out
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [WIDTH-1:0] last_cnt;

  // ==========================================================
  // Divide source ticks; ratio 0 behaves as undivided
  always_comb begin
    last_cnt = (ratio == '0) ? '0 : ratio - WIDTH'(1);
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!gate_en) begin
      cnt_next = '0;
    end else if (src_tick) begin
      if (cnt_reg >= last_cnt) begin
        cnt_next = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule : rcc_clk_div

// *** src/rcc_reset_clock_control.sv ***
`timescale 1ns/10ps
// Contract
// RULE1: Power-on resets the chip
// RULE2: Brownout in reset mode resets system
// RULE3: Chip enable pin low resets chip
// RULE4: Watchdog timeout resets system
// RULE5: Software request performs system reset
// RULE6: Debugger request performs debug reset
// RULE7: Power-on and enable pin reset everything
// RULE8: Brownout, software, watchdog spare always-on logic; here the always-on timer is reset with the system
// RULE9: Debug resets requester, optionally other, peripherals
// RULE10: Crystal feeds peripherals undivided or divided
// RULE11: Fast oscillator direct to network CPU
// RULE12: Slow oscillator drives modulator, touch, keyscan; here only modulator and touch ticks, no keyscan output
// RULE13: PLL divided clocks CPUs, fast peripherals
// RULE14: Sources selectable, gated and divided
// RULE15: Brownout raises interrupt or reset by mode
// RULE16: Resets assert async, release through two stages; here only power-on asserts async, other requests at the next clock edge
module rcc_reset_clock_control import rcc_pkg::*; #(
  parameter int DIV_WIDTH = RCC_DIV_WIDTH,
  parameter int HOLD_CYCLES = RCC_HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chip_enable,
  input wire logic brownout_detector_low,
  input wire logic brownout_detector_enable,
  input wire logic brownout_reset_mode,
  input wire logic watchdog_timeout_reset,
  input wire logic software_reset,
  input wire logic debugger_reset,
  input wire logic debug_core_select,
  input wire logic debug_reset_other,
  input wire logic debug_reset_periph,
  input wire logic crystal_clock_tick,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_tick,
  input wire logic system_pll_tick,
  input wire logic periph_clk_select,
  input wire logic network_clk_select,
  input wire logic [RCC_NUM_CLK-1:0] clk_gate_enable,
  input wire logic [DIV_WIDTH-1:0] periph_div,
  input wire logic [DIV_WIDTH-1:0] network_div,
  input wire logic [DIV_WIDTH-1:0] app_div,
  input wire logic [DIV_WIDTH-1:0] hsp_div,
  output logic always_on_domain_rst_n,
  output logic aon_timer_rst_n,
  output logic system_rst_n,
  output logic application_cpu_rst_n,
  output logic network_cpu_rst_n,
  output logic periph_rst_n,
  output logic brownout_irq,
  output logic [RCC_NUM_CLK-1:0] clk_tick_out
);
  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES - 1);
  // ==========================================================
  // Parameter checks
  if (DIV_WIDTH < 2 || HOLD_CYCLES < 2) begin : g_bad_param
    $error("rcc_reset_clock_control: DIV_WIDTH and HOLD_CYCLES must be at least 2");
  end
  // ==========================================================
  // Internal reset release
  logic [1:0] por_sync_reg;
  logic [1:0] por_sync_next;
  logic por_sync_n;
  always_comb begin
    por_sync_next = {por_sync_reg[0], 1'b1};
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_sync_reg <= 2'h0;
    end else begin
      por_sync_reg <= por_sync_next;
    end
  end
  assign por_sync_n = por_sync_reg[1];
  // ==========================================================
  // Pin synchronisers, a change counts when stages two and three agree
  logic [RCC_NUM_PIN-1:0] pin_raw;
  logic [RCC_NUM_PIN-1:0] sync1_reg;
  logic [RCC_NUM_PIN-1:0] sync2_reg;
  logic [RCC_NUM_PIN-1:0] sync3_reg;
  logic [RCC_NUM_PIN-1:0] pin_level_reg;
  logic [RCC_NUM_PIN-1:0] pin_level_next;
  assign pin_raw = {debugger_reset, brownout_detector_low, chip_enable};
  always_comb begin
    pin_level_next = pin_level_reg;
    for (int i = 0; i < RCC_NUM_PIN; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) begin
        pin_level_next[i] = sync3_reg[i];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge por_sync_n) begin
    if (!por_sync_n) begin
      sync1_reg <= RCC_PIN_RST;
      sync2_reg <= RCC_PIN_RST;
      sync3_reg <= RCC_PIN_RST;
      pin_level_reg <= RCC_PIN_RST;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_level_reg <= pin_level_next;
    end
  end
  // ==========================================================
  // Reset sources
  logic whole_req;
  logic chip_req;
  logic bor_req;
  logic dbg_level;
  logic irq_reg;
  logic irq_next;
  assign chip_req = !pin_level_reg[RCC_PIN_CHIP_EN]; // RULE3
  assign whole_req = chip_req || !por_sync_n; // RULE1
  assign dbg_level = pin_level_reg[RCC_PIN_DBG];
  // Reset mode holds the system until the supply recovers
  assign bor_req = brownout_detector_enable && brownout_reset_mode
                   && pin_level_reg[RCC_PIN_BOD]; // RULE2 RULE15
  always_comb begin
    irq_next = brownout_detector_enable && !brownout_reset_mode
               && pin_level_reg[RCC_PIN_BOD]; // RULE15
  end
  always_ff @(posedge sys_clk or negedge por_sync_n) begin
    if (!por_sync_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end
  assign brownout_irq = irq_reg;
  // ==========================================================
  // System reset stretcher for one-cycle requests
  rcc_seq_type sys_state_reg;
  rcc_seq_type sys_state_next;
  logic [HOLD_W-1:0] sys_cnt_reg;
  logic [HOLD_W-1:0] sys_cnt_next;
  logic sys_event;
  assign sys_event = watchdog_timeout_reset || software_reset; // RULE4 RULE5
  always_comb begin
    sys_state_next = sys_state_reg;
    sys_cnt_next = sys_cnt_reg;
    unique case (sys_state_reg)
      RCC_SEQ_IDLE: begin
        if (sys_event) begin
          sys_state_next = RCC_SEQ_HOLD;
          sys_cnt_next = HOLD_LOAD;
        end
      end
      RCC_SEQ_HOLD: begin
        if (sys_event) begin
          sys_cnt_next = HOLD_LOAD;
        end else if (sys_cnt_reg == '0) begin
          sys_state_next = RCC_SEQ_IDLE;
        end else begin
          sys_cnt_next = sys_cnt_reg - HOLD_W'(1);
        end
      end
      default: begin
        sys_state_next = RCC_SEQ_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge por_sync_n) begin
    if (!por_sync_n) begin
      sys_state_reg <= RCC_SEQ_IDLE;
      sys_cnt_reg <= '0;
    end else begin
      sys_state_reg <= sys_state_next;
      sys_cnt_reg <= sys_cnt_next;
    end
  end
  // ==========================================================
  // Debug reset stretcher; target choice caught at the request edge
  rcc_seq_type dbg_state_reg;
  rcc_seq_type dbg_state_next;
  logic [HOLD_W-1:0] dbg_cnt_reg;
  logic [HOLD_W-1:0] dbg_cnt_next;
  logic dbg_prev_reg;
  logic [2:0] dbg_cfg_reg;
  logic [2:0] dbg_cfg_next;
  logic dbg_start;
  assign dbg_start = dbg_level && !dbg_prev_reg; // RULE6
  always_comb begin
    dbg_state_next = dbg_state_reg;
    dbg_cnt_next = dbg_cnt_reg;
    dbg_cfg_next = dbg_cfg_reg;
    if (dbg_start) begin
      dbg_cfg_next = {debug_reset_periph, debug_reset_other, debug_core_select};
    end
    unique case (dbg_state_reg)
      RCC_SEQ_IDLE: begin
        if (dbg_start) begin
          dbg_state_next = RCC_SEQ_HOLD;
          dbg_cnt_next = HOLD_LOAD;
        end
      end
      RCC_SEQ_HOLD: begin
        if (dbg_level) begin
          dbg_cnt_next = HOLD_LOAD;
        end else if (dbg_cnt_reg == '0) begin
          dbg_state_next = RCC_SEQ_IDLE;
        end else begin
          dbg_cnt_next = dbg_cnt_reg - HOLD_W'(1);
        end
      end
      default: begin
        dbg_state_next = RCC_SEQ_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or negedge por_sync_n) begin
    if (!por_sync_n) begin
      dbg_state_reg <= RCC_SEQ_IDLE;
      dbg_cnt_reg <= '0;
      dbg_prev_reg <= 1'b0;
      dbg_cfg_reg <= 3'h0;
    end else begin
      dbg_state_reg <= dbg_state_next;
      dbg_cnt_reg <= dbg_cnt_next;
      dbg_prev_reg <= dbg_level;
      dbg_cfg_reg <= dbg_cfg_next;
    end
  end
  // ==========================================================
  // Reset domain routing
  logic sys_grp;
  logic dbg_act;
  logic [RCC_NUM_DOM-1:0] dom_req;
  assign sys_grp = bor_req || (sys_state_reg == RCC_SEQ_HOLD); // RULE8
  assign dbg_act = (dbg_state_reg == RCC_SEQ_HOLD);
  always_comb begin
    dom_req[RCC_DOM_AON] = whole_req; // RULE7
    dom_req[RCC_DOM_TIMER] = whole_req || sys_grp; // RULE8
    dom_req[RCC_DOM_SYS] = whole_req || sys_grp;
    dom_req[RCC_DOM_APP] = whole_req || sys_grp
                           || (dbg_act && (!dbg_cfg_reg[0] || dbg_cfg_reg[1])); // RULE9
    dom_req[RCC_DOM_NET] = whole_req || sys_grp
                           || (dbg_act && (dbg_cfg_reg[0] || dbg_cfg_reg[1])); // RULE9
    dom_req[RCC_DOM_PER] = whole_req || sys_grp || (dbg_act && dbg_cfg_reg[2]);
  end
  // ==========================================================
  // Two-stage release; power-on clears both stages at once
  logic [RCC_NUM_DOM-1:0] stage_reg;
  logic [RCC_NUM_DOM-1:0] stage_next;
  logic [RCC_NUM_DOM-1:0] out_reg;
  logic [RCC_NUM_DOM-1:0] out_next;
  for (genvar d = 0; d < RCC_NUM_DOM; d++) begin : g_dom
    always_comb begin
      stage_next[d] = !dom_req[d]; // RULE16
      out_next[d] = !dom_req[d] && stage_reg[d];
    end
    always_ff @(posedge sys_clk or negedge por_sync_n) begin
      if (!por_sync_n) begin
        stage_reg[d] <= 1'b0;
        out_reg[d] <= 1'b0;
      end else begin
        stage_reg[d] <= stage_next[d];
        out_reg[d] <= out_next[d];
      end
    end
  end
  assign always_on_domain_rst_n = out_reg[RCC_DOM_AON];
  assign aon_timer_rst_n = out_reg[RCC_DOM_TIMER];
  assign system_rst_n = out_reg[RCC_DOM_SYS];
  assign application_cpu_rst_n = out_reg[RCC_DOM_APP];
  assign network_cpu_rst_n = out_reg[RCC_DOM_NET];
  assign periph_rst_n = out_reg[RCC_DOM_PER];
  // ==========================================================
  // Clock source select, gating and division
  logic [RCC_NUM_CLK-1:0] src_sel;
  logic [DIV_WIDTH-1:0] ratio_sel [RCC_NUM_CLK];
  always_comb begin
    src_sel[RCC_CLK_PER] = periph_clk_select ? fast_osc_tick : crystal_clock_tick; // RULE10
    ratio_sel[RCC_CLK_PER] = periph_div;
    src_sel[RCC_CLK_NET] = network_clk_select ? system_pll_tick : fast_osc_tick; // RULE11
    ratio_sel[RCC_CLK_NET] = network_clk_select ? network_div : DIV_WIDTH'(1);
    src_sel[RCC_CLK_APP] = system_pll_tick; // RULE13
    ratio_sel[RCC_CLK_APP] = app_div;
    src_sel[RCC_CLK_HSP] = system_pll_tick;
    ratio_sel[RCC_CLK_HSP] = hsp_div;
    src_sel[RCC_CLK_SDM] = slow_osc_tick; // RULE12
    ratio_sel[RCC_CLK_SDM] = DIV_WIDTH'(1);
    src_sel[RCC_CLK_TOUCH] = slow_osc_tick;
    ratio_sel[RCC_CLK_TOUCH] = DIV_WIDTH'(1);
  end
  for (genvar c = 0; c < RCC_NUM_CLK; c++) begin : g_clk
    rcc_clk_div #(
      .WIDTH(DIV_WIDTH)
    ) u_div ( // RULE14
      .sys_clk(sys_clk),
      .rst_n(por_sync_n),
      .src_tick(src_sel[c]),
      .gate_en(clk_gate_enable[c]),
      .ratio(ratio_sel[c]),
      .tick_out(clk_tick_out[c])
    );
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!por_sync_n);
  sequence s_quiet_chip;
    (!chip_req && por_sync_n) [*3];
  endsequence
  sequence s_sys_released;
    !dom_req[RCC_DOM_SYS] [*2];
  endsequence
  por_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    $rose(por_sync_n) |-> !always_on_domain_rst_n && !system_rst_n)
    else $error("power-on did not hold the chip in reset");
  bor_sys_a: assert property (bor_req |-> ##[1:2] !system_rst_n && !aon_timer_rst_n) // RULE2
    else $error("brownout did not reset the system");
  chip_all_a: assert property (chip_req |-> ##[1:2] (out_reg == '0)) // RULE7
    else $error("enable pin did not reset every domain");
  wdg_sys_a: assert property (watchdog_timeout_reset |-> ##[1:2] !system_rst_n) // RULE4
    else $error("watchdog timeout did not reset the system");
  sw_sys_a: assert property (software_reset |-> ##[1:2] !application_cpu_rst_n) // RULE5
    else $error("software request did not reset the system");
  aon_kept_a: assert property (s_quiet_chip |-> always_on_domain_rst_n) // RULE8
    else $error("always-on domain reset without a chip reset");
  dbg_core_a: assert property (dbg_start && !debug_core_select // RULE9
    |-> ##[2:3] !application_cpu_rst_n)
    else $error("debug reset missed the requesting core");
  bod_irq_a: assert property (brownout_detector_enable && !brownout_reset_mode // RULE15
    && pin_level_reg[RCC_PIN_BOD] |=> brownout_irq && !bor_req)
    else $error("brownout interrupt mode misbehaved");
  sys_release_a: assert property (s_sys_released |=> system_rst_n) // RULE16
    else $error("system reset not released after two stages");
  net_direct_a: assert property (fast_osc_tick && !network_clk_select // RULE11
    && clk_gate_enable[RCC_CLK_NET] |=> clk_tick_out[RCC_CLK_NET])
    else $error("network clock not passed directly");
  gate_off_a: assert property (!clk_gate_enable[RCC_CLK_SDM] |=> !clk_tick_out[RCC_CLK_SDM]) // RULE14
    else $error("gated clock still ticking");
  slow_drive_a: assert property (slow_osc_tick && clk_gate_enable[RCC_CLK_TOUCH] // RULE12
    |=> clk_tick_out[RCC_CLK_TOUCH])
    else $error("slow oscillator tick lost");
endmodule : rcc_reset_clock_control

// *** tb/rcc_far_side.sv ***
`timescale 1ns/10ps
module rcc_far_side (
  input wire logic sys_clk,
  output logic supply_low,
  output logic dog_pulse,
  output logic soft_pulse,
  output logic debug_req
);
  // ==========================================================
  // Requesters outside the unit, always moved 2 ns past the edge
  initial begin
    supply_low = 1'b0;
    dog_pulse = 1'b0;
    soft_pulse = 1'b0;
    debug_req = 1'b0;
  end

  task automatic fire_dog();
    @(posedge sys_clk);
    #2;
    dog_pulse = 1'b1;
    @(posedge sys_clk);
    #2;
    dog_pulse = 1'b0;
  endtask : fire_dog

  task automatic fire_soft();
    @(posedge sys_clk);
    #2;
    soft_pulse = 1'b1;
    @(posedge sys_clk);
    #2;
    soft_pulse = 1'b0;
  endtask : fire_soft

  // Levels, not pulses: the detector and the debug port hold them
  task automatic set_supply(input logic v);
    @(posedge sys_clk);
    #2;
    supply_low = v;
  endtask : set_supply

  task automatic set_debug(input logic v);
    @(posedge sys_clk);
    #2;
    debug_req = v;
  endtask : set_debug
endmodule : rcc_far_side

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  import rcc_pkg::*;
  // ==========================================================
  // Settings; short hold keeps the run brief
  localparam int HOLD = 6;
  localparam int MAX_CYCLES = 10000;
  localparam logic [5:0] SYSTEM_MASK = 6'h01;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_enable = 1'b1;
  logic brown_en = 1'b0;
  logic brown_mode = 1'b0;
  logic core_sel = 1'b0;
  logic other_en = 1'b0;
  logic periph_en = 1'b0;
  logic per_sel = 1'b0;
  logic net_sel = 1'b0;
  logic [3:0] src = 4'h0;
  logic [5:0] gate = 6'h00;
  logic [7:0] dv [4] = '{default: 8'h00};
  wire supply_low, dog_pulse, soft_pulse, debug_req, irq;
  wire [5:0] rst_vec;
  wire [5:0] ticks;
  int tick_cnt [6] = '{default: 0};
  int cycles = 0;
  int checked = 0;
  int num_errors = 0;

  always #12.5 sys_clk = ~sys_clk;

  rcc_far_side far (.sys_clk(sys_clk), .supply_low(supply_low), .dog_pulse(dog_pulse),
    .soft_pulse(soft_pulse), .debug_req(debug_req));

  rcc_reset_clock_control #(.HOLD_CYCLES(HOLD)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .chip_enable(chip_enable),
    .brownout_detector_low(supply_low), .brownout_detector_enable(brown_en),
    .brownout_reset_mode(brown_mode), .watchdog_timeout_reset(dog_pulse),
    .software_reset(soft_pulse), .debugger_reset(debug_req),
    .debug_core_select(core_sel), .debug_reset_other(other_en),
    .debug_reset_periph(periph_en), .crystal_clock_tick(src[0]),
    .fast_osc_tick(src[1]), .slow_osc_tick(src[2]), .system_pll_tick(src[3]),
    .periph_clk_select(per_sel), .network_clk_select(net_sel),
    .clk_gate_enable(gate), .periph_div(dv[0]), .network_div(dv[1]),
    .app_div(dv[2]), .hsp_div(dv[3]),
    .always_on_domain_rst_n(rst_vec[RCC_DOM_AON]),
    .aon_timer_rst_n(rst_vec[RCC_DOM_TIMER]), .system_rst_n(rst_vec[RCC_DOM_SYS]),
    .application_cpu_rst_n(rst_vec[RCC_DOM_APP]),
    .network_cpu_rst_n(rst_vec[RCC_DOM_NET]), .periph_rst_n(rst_vec[RCC_DOM_PER]),
    .brownout_irq(irq), .clk_tick_out(ticks));

  // ==========================================================
  // Monitors and helpers
  always @(posedge sys_clk) begin
    for (int i = 0; i < 6; i++) begin
      tick_cnt[i] <= tick_cnt[i] + int'(ticks[i] === 1'b1);
    end
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic step();
    @(posedge sys_clk);
    #2;
  endtask : step

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %0h seen %0h", what, want, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  function automatic int div_n(input logic [7:0] r);
    return (r < 8'h02) ? 1 : int'(r);
  endfunction : div_n

  function automatic logic [5:0] debug_mask(input logic s, input logic o, input logic p);
    logic [5:0] m;
    m = 6'h3F;
    if (!s || o) m[RCC_DOM_APP] = 1'b0;
    if (s || o) m[RCC_DOM_NET] = 1'b0;
    if (p) m[RCC_DOM_PER] = 1'b0;
    return m;
  endfunction : debug_mask

  // Long enough for sync, hold and the two-stage release
  task automatic settle_ok();
    repeat (HOLD + 10) step();
    check("resets idle", 16'({irq, rst_vec}), 16'h003F);
  endtask : settle_ok

  // ==========================================================
  // One random clock round; gate dropped first to clear dividers
  task automatic clk_round();
    int n [4];
    int e [6];
    int base [6];
    gate = 6'h00;
    repeat (3) step();
    per_sel = 1'($urandom);
    net_sel = 1'($urandom);
    gate = 6'($urandom);
    foreach (dv[i]) dv[i] = 8'($urandom_range(4, 0));
    base = tick_cnt;
    n = '{default: 0};
    repeat ($urandom_range(30, 4)) begin
      src = 4'($urandom);
      for (int k = 0; k < 4; k++) n[k] += int'(src[k]);
      step();
    end
    src = 4'h0;
    repeat (4) step();
    e[RCC_CLK_PER] = n[per_sel ? 1 : 0] / div_n(dv[0]);
    e[RCC_CLK_NET] = net_sel ? n[3] / div_n(dv[1]) : n[1];
    e[RCC_CLK_APP] = n[3] / div_n(dv[2]);
    e[RCC_CLK_HSP] = n[3] / div_n(dv[3]);
    e[RCC_CLK_SDM] = n[2];
    e[RCC_CLK_TOUCH] = n[2];
    for (int i = 0; i < 6; i++) begin
      check("tick count", 16'(tick_cnt[i] - base[i]), 16'(gate[i] ? e[i] : 0));
    end
  endtask : clk_round

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(57));
    repeat (5) step();
    check("in power-on reset", 16'({irq, ticks, rst_vec}), 16'h0000);
    repeat (5) step();
    rst_n = 1'b1;
    repeat (6) step();
    check("after power-on", 16'(rst_vec), 16'h003F);
    chip_enable = 1'b0;
    repeat (8) step();
    check("enable pin reset", 16'(rst_vec), 16'h0000);
    chip_enable = 1'b1;
    settle_ok();
    far.fire_soft();
    repeat (2) step();
    check("software reset", 16'(rst_vec), 16'(SYSTEM_MASK));
    // Watchdog lands mid-hold; the stretch must restart from it
    far.fire_dog();
    repeat (7) step();
    check("watchdog restart", 16'(rst_vec), 16'(SYSTEM_MASK));
    settle_ok();
    for (int k = 0; k < 4; k++) begin
      brown_en = k[0];
      brown_mode = k[1];
      far.set_supply(1'b1);
      repeat (8) step();
      check("brownout resets", 16'(rst_vec), 16'((k == 3) ? SYSTEM_MASK : 6'h3F));
      check("brownout irq", 16'(irq), 16'(k == 1));
      far.set_supply(1'b0);
      settle_ok();
    end
    for (int k = 0; k < 8; k++) begin
      {core_sel, other_en, periph_en} = 3'(k);
      far.set_debug(1'b1);
      repeat (8) step();
      check("debug reset", 16'(rst_vec), 16'(debug_mask(k[2], k[1], k[0])));
      // Late config changes must not reach a request already taken
      {core_sel, other_en, periph_en} = ~3'(k);
      repeat (3) step();
      check("debug held", 16'(rst_vec), 16'(debug_mask(k[2], k[1], k[0])));
      far.set_debug(1'b0);
      settle_ok();
    end
    repeat (40) clk_round();
    // Second power-on in mid-run; outputs stay low three edges past release
    rst_n = 1'b0;
    repeat (3) step();
    check("mid-run power-on", 16'({irq, ticks, rst_vec}), 16'h0000);
    rst_n = 1'b1;
    repeat (3) step();
    check("release held", 16'(rst_vec), 16'h0000);
    repeat (3) step();
    check("after second power-on", 16'(rst_vec), 16'h003F);
    complete_run();
  end
endmodule : tb
